// *** core/dmp_prescaler.sv ***
// dual modulus divider core with standby and edge variant
`timescale 1ns/1ps
module dmp_prescaler #(
  parameter bit FALLING_VARIANT = 1'b0 // 1: counting edge is falling
) (
  input wire logic core_clk, // high-speed input clock
  input wire logic rst_n, // async reset, active low
  input wire logic ratio_range_select, // 1: 64/65, 0: 128/129
  input wire logic modulus_select, // 1: smaller, 0: larger divisor
  input wire logic low_power_hold_n, // 0: standby
  output logic div_out, // divided clock output
  output logic running // 1 while dividing
);
  logic [2:0] pins_s;
  logic range_s;
  logic mod_s;
  logic hold_n_s;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] div_q, div_d;
  logic out_q, out_d;
  logic run_q, run_d;
  dmp_pkg::dmp_state_e st_q, st_d;

  // elaboration check: counter arithmetic assumes eight bits
  if (dmp_pkg::DMP_CNT_W != 8) begin : g_bad_cnt_w
    $error("counter width must be 8");
  end

  dmp_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({ratio_range_select, modulus_select, low_power_hold_n}),
    .sync_out(pins_s)
  );
  assign range_s = pins_s[2];
  assign mod_s = pins_s[1];
  assign hold_n_s = pins_s[0];

  // divisor from the two select levels
  function automatic logic [7:0] pick_div(input logic rng, input logic md);
    logic [7:0] r;
    r = dmp_pkg::DMP_DIV_LARGE_HI;
    case ({rng, md})
      2'b11: r = dmp_pkg::DMP_DIV_SMALL_LO;
      2'b10: r = dmp_pkg::DMP_DIV_SMALL_HI;
      2'b01: r = dmp_pkg::DMP_DIV_LARGE_LO;
      default: r = dmp_pkg::DMP_DIV_LARGE_HI;
    endcase
    return r;
  endfunction

  // level at start of period: the counting edge opens each period
  function automatic logic lead_lvl(input logic falling);
    return falling ? 1'b0 : 1'b1;
  endfunction

  // last count of a period for divisor d
  function automatic logic is_wrap(input logic [7:0] c,
    input logic [7:0] d);
    return c == 8'(d - 8'h01);
  endfunction

  // count just before the second half of a period
  function automatic logic is_half(input logic [7:0] c,
    input logic [7:0] d);
    return c == 8'((d >> 1) - 8'h01);
  endfunction

  // next-state: count, divisor latch, output level
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    div_d = div_q;
    out_d = out_q;
    case (st_q)
      dmp_pkg::DMP_ST_HOLD: begin
        cnt_d = dmp_pkg::DMP_CNT_RST;
        out_d = ~lead_lvl(FALLING_VARIANT);
        if (hold_n_s) begin
          st_d = dmp_pkg::DMP_ST_RUN;
          div_d = pick_div(range_s, mod_s);
        end
      end
      dmp_pkg::DMP_ST_RUN: begin
        if (!hold_n_s) begin
          st_d = dmp_pkg::DMP_ST_HOLD;
          cnt_d = dmp_pkg::DMP_CNT_RST;
          out_d = ~lead_lvl(FALLING_VARIANT);
        end else if (is_wrap(cnt_q, div_q)) begin
          cnt_d = dmp_pkg::DMP_CNT_RST;
          div_d = pick_div(range_s, mod_s);
          out_d = lead_lvl(FALLING_VARIANT);
        end else begin
          cnt_d = 8'(cnt_q + 8'h01);
          if (is_half(cnt_q, div_q)) begin
            out_d = ~lead_lvl(FALLING_VARIANT);
          end
        end
      end
      default: begin
        st_d = dmp_pkg::DMP_ST_HOLD;
        cnt_d = dmp_pkg::DMP_CNT_RST;
      end
    endcase
    run_d = (st_d == dmp_pkg::DMP_ST_RUN);
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= dmp_pkg::DMP_ST_HOLD;
      cnt_q <= dmp_pkg::DMP_CNT_RST;
      div_q <= dmp_pkg::DMP_DIV_RST;
      out_q <= ~lead_lvl(FALLING_VARIANT);
      run_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      div_q <= div_d;
      out_q <= out_d;
      run_q <= run_d;
    end
  end

  assign div_out = out_q;
  assign running = run_q; // registered run flag

  // checks
  property p_div_legal;
    @(posedge core_clk) disable iff (!rst_n)
    (div_q == dmp_pkg::DMP_DIV_SMALL_LO) ||
    (div_q == dmp_pkg::DMP_DIV_SMALL_HI) ||
    (div_q == dmp_pkg::DMP_DIV_LARGE_LO) ||
    (div_q == dmp_pkg::DMP_DIV_LARGE_HI);
  endproperty
  a_div_legal: assert property (p_div_legal)
    else $error("divisor outside the two pairs");

  property p_pick_small;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_RUN && hold_n_s &&
     cnt_q == 8'(div_q - 8'h01) && range_s && mod_s)
    |=> (div_q == dmp_pkg::DMP_DIV_SMALL_LO);
  endproperty
  a_pick_small: assert property (p_pick_small)
    else $error("range high, modulus high did not give 64");

  property p_pick_large;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_RUN && hold_n_s &&
     cnt_q == 8'(div_q - 8'h01) && !range_s && !mod_s)
    |=> (div_q == dmp_pkg::DMP_DIV_LARGE_HI);
  endproperty
  a_pick_large: assert property (p_pick_large)
    else $error("range low, modulus low did not give 129");

  property p_hold_stops;
    @(posedge core_clk) disable iff (!rst_n)
    !hold_n_s |=> (st_q == dmp_pkg::DMP_ST_HOLD && cnt_q == 8'h00 &&
                   out_q == ~lead_lvl(FALLING_VARIANT));
  endproperty
  a_hold_stops: assert property (p_hold_stops)
    else $error("standby did not stop the divider");

  property p_lead_edge;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_RUN && hold_n_s &&
     cnt_q == 8'(div_q - 8'h01))
    |=> (out_q == lead_lvl(FALLING_VARIANT) && cnt_q == 8'h00);
  endproperty
  a_lead_edge: assert property (p_lead_edge)
    else $error("period did not open with the counting edge");

  property p_no_mid_change;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_RUN && cnt_q != 8'(div_q - 8'h01))
    |=> $stable(div_q);
  endproperty
  a_no_mid_change: assert property (p_no_mid_change)
    else $error("divisor changed inside a period");

  property p_count_step;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_RUN && hold_n_s &&
     cnt_q != 8'(div_q - 8'h01))
    |=> (cnt_q == 8'($past(cnt_q) + 8'h01));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance by one");

  property p_cnt_bound;
    @(posedge core_clk) disable iff (!rst_n)
    cnt_q < div_q;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("counter ran past the divisor");

  property p_half_edge;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_RUN && hold_n_s &&
     cnt_q == 8'((div_q >> 1) - 8'h01))
    |=> (div_out == FALLING_VARIANT);
  endproperty
  a_half_edge: assert property (p_half_edge)
    else $error("second half of the period has the wrong level");

  property p_out_steady;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_RUN && hold_n_s &&
     cnt_q != 8'(div_q - 8'h01) &&
     cnt_q != 8'((div_q >> 1) - 8'h01))
    |=> $stable(div_out);
  endproperty
  a_out_steady: assert property (p_out_steady)
    else $error("output moved away from a period edge");

  property p_resume;
    @(posedge core_clk) disable iff (!rst_n)
    (st_q == dmp_pkg::DMP_ST_HOLD && hold_n_s)
    |=> (running && cnt_q == 8'h00 && div_out == FALLING_VARIANT);
  endproperty
  a_resume: assert property (p_resume)
    else $error("release of standby did not restart the divider");

  c_wrap64: cover property (@(posedge core_clk) disable iff (!rst_n)
    div_q == dmp_pkg::DMP_DIV_SMALL_LO && cnt_q == 8'h3f);
  c_wrap129: cover property (@(posedge core_clk) disable iff (!rst_n)
    div_q == dmp_pkg::DMP_DIV_LARGE_HI && cnt_q == 8'h80);
  c_standby: cover property (@(posedge core_clk) disable iff (!rst_n)
    st_q == dmp_pkg::DMP_ST_RUN ##1 st_q == dmp_pkg::DMP_ST_HOLD);
endmodule

// *** common/dmp_pkg.sv ***
// constants and types for the dual modulus prescaler
package dmp_pkg;
  localparam int unsigned DMP_CNT_W = 8;
  localparam logic [7:0] DMP_DIV_SMALL_LO = 8'h40; // 64
  localparam logic [7:0] DMP_DIV_SMALL_HI = 8'h41; // 65
  localparam logic [7:0] DMP_DIV_LARGE_LO = 8'h80; // 128
  localparam logic [7:0] DMP_DIV_LARGE_HI = 8'h81; // 129
  localparam logic [7:0] DMP_CNT_RST = 8'h00;
  localparam logic [7:0] DMP_DIV_RST = 8'h81;
  localparam logic DMP_SYNC_RST = 1'b0;
  typedef enum logic [0:0] {
    DMP_ST_HOLD = 1'b0,
    DMP_ST_RUN = 1'b1
  } dmp_state_e;
endpackage

// *** core/dmp_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dmp_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // a zero-wide synchroniser is refused
  if (WIDTH < 1) begin : g_bad_width
    $error("synchroniser width must be at least 1");
  end

  // first stage read only by the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{dmp_pkg::DMP_SYNC_RST}};
      sync_q <= {WIDTH{dmp_pkg::DMP_SYNC_RST}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// *** bench/dmp_synth_model.sv ***
// synthesizer counter model that steers the prescaler modulus
`timescale 1ns/1ps
module dmp_synth_model #(
  parameter bit FALLING_EDGE = 1'b0 // 1: counts on negative-going edges
) (
  input wire logic core_clk, // prescaler input clock
  input wire logic div_out, // divided clock from the device
  input wire logic want_small, // modulus wanted by the bench
  output logic modulus_select, // steers the divisor
  output int edges, // counting edges seen
  output int last_period // clocks between counting edges
);
  logic prev_q = FALLING_EDGE;
  int cnt_q = 0;
  initial edges = 0;
  initial last_period = 0;
  // count clocks between counting edges, pass the wanted modulus on every clock
  always @(posedge core_clk) begin
    prev_q <= div_out;
    modulus_select <= want_small;
    cnt_q <= cnt_q + 1;
    if (FALLING_EDGE ? (prev_q && !div_out) : (!prev_q && div_out)) begin
      edges <= edges + 1;
      last_period <= cnt_q;
      cnt_q <= 1;
    end
  end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the dual modulus prescaler
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic range_q = 1'b1;
  logic small_q = 1'b1;
  logic hold_n = 1'b1;
  logic mod_r, mod_f, out_r, out_f, run_r, run_f;
  int edg_r, edg_f, per_r, per_f;
  int n_errors = 0;
  int n_checks = 0;
  // 40 MHz input clock
  always #12.5 core_clk = ~core_clk;
  // rising and falling variants side by side
  dmp_prescaler #(.FALLING_VARIANT(1'b0)) DUT (.core_clk(core_clk),
    .rst_n(rst_n), .ratio_range_select(range_q), .modulus_select(mod_r),
    .low_power_hold_n(hold_n), .div_out(out_r), .running(run_r));
  dmp_prescaler #(.FALLING_VARIANT(1'b1)) DUT_fall (.core_clk(core_clk),
    .rst_n(rst_n), .ratio_range_select(range_q), .modulus_select(mod_f),
    .low_power_hold_n(hold_n), .div_out(out_f), .running(run_f));
  dmp_synth_model #(.FALLING_EDGE(1'b0)) syn_r (.core_clk(core_clk),
    .div_out(out_r), .want_small(small_q), .modulus_select(mod_r),
    .edges(edg_r), .last_period(per_r));
  dmp_synth_model #(.FALLING_EDGE(1'b1)) syn_f (.core_clk(core_clk),
    .div_out(out_f), .want_small(small_q), .modulus_select(mod_f),
    .edges(edg_f), .last_period(per_f));
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // wait for n counting edges on both outputs, bounded
  task automatic wait_edges(int n);
    int er, ef, k;
    er = edg_r;
    ef = edg_f;
    for (k = 0; k < 2000 && (edg_r < er + n || edg_f < ef + n); k++) begin
      @(posedge core_clk);
    end
    if (edg_r < er + n || edg_f < ef + n) begin
      n_errors++;
      $display("BAD counting edges expected %0d seen %0d", n,
        (edg_r - er < edg_f - ef) ? edg_r - er : edg_f - ef);
      test_done();
    end
  endtask
  // all four divisors, range set before modulus
  task automatic t_ratios();
    logic [7:0] exp;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      range_q <= i[1];
      @(posedge core_clk);
      small_q <= i[0];
      exp = i[1] ? (i[0] ? dmp_pkg::DMP_DIV_SMALL_LO
                         : dmp_pkg::DMP_DIV_SMALL_HI)
                 : (i[0] ? dmp_pkg::DMP_DIV_LARGE_LO
                         : dmp_pkg::DMP_DIV_LARGE_HI);
      wait_edges(3);
      chk("period rising", {24'h0000_00, exp}, per_r);
      chk("period falling", {24'h0000_00, exp}, per_f);
    end
    $display("test ratios done");
  endtask
  // standby stops both variants at idle level, release resumes
  task automatic t_standby();
    int er;
    @(posedge core_clk);
    hold_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    er = edg_r + edg_f;
    chk("running rising", 0, {31'h0, run_r});
    chk("idle rising", 0, {31'h0, out_r});
    chk("idle falling", 1, {31'h0, out_f});
    repeat (300) @(posedge core_clk);
    chk("edges in standby", er, edg_r + edg_f);
    hold_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("running falling", 1, {31'h0, run_f});
    wait_edges(3);
    chk("period resumed", 32'h0000_0040, per_r);
    $display("test standby done");
  endtask
  // modulus flipped mid-period: running period keeps its divisor
  task automatic t_midswitch();
    wait_edges(1);
    repeat (10) @(posedge core_clk);
    small_q <= 1'b0;
    wait_edges(1);
    chk("period kept", 32'h0000_0040, per_r);
    chk("period kept falling", 32'h0000_0040, per_f);
    wait_edges(1);
    chk("period switched", 32'h0000_0041, per_r);
    chk("period switched falling", 32'h0000_0041, per_f);
    $display("test midswitch done");
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_ratios();
    t_standby();
    t_midswitch();
    test_done();
  end
endmodule
